// ### fieldbus_status_indicator.sv
// module: front-panel status indicators and configuration bits
//
// Notes on behaviour
// - error LED dark while communication works without any error pending.
// - booting error (INIT with change flag 0x01) makes error LED flicker.
// - autonomous state change (change flag 0x01) gives error LED single flash.
// - application watchdog timeout gives error LED a double flash.
// - process-data watchdog timeout lights error LED continuously.
// - run LED dark in INIT.
// - run LED blinks in PRE-OPERATIONAL.
// - run LED single flash in SAFE-OPERATIONAL.
// - run LED lit in OPERATIONAL.
// - run LED flickers while booting before INIT or in BOOTSTRAP.
// - added axes in three bits: 000 none, bit 0 one, bit 1 two.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
module fieldbus_status_indicator
   import fbs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
)(
   // clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   // protocol controller
   input  wire slave_status_t slv,
   // indicators
   output logic               error_indicator_led,
   output logic               run_indicator_led,
   // configuration towards the drive
   output logic      [1:0]    added_axis_count,
   output logic               axis_config_invalid,
   output logic               remote_mode,
   output logic               count_units,
   // interrupt
   output logic               irq
);

   // added-axis bits to a count; illegal codes map to zero
   function automatic logic [1:0] axis_count_of(input logic [2:0] f);
      unique case (f)
         AXIS_ONE: axis_count_of = 2'h1;
         AXIS_TWO: axis_count_of = 2'h2;
         default:  axis_count_of = 2'h0;
      endcase
   endfunction : axis_count_of

   // register state
   logic [15:0]       axis_word_r;
   logic [15:0]       mode_word_r;
   logic [IRQ_W-1:0]  istat_r;
   logic [IRQ_W-1:0]  istat_nxt;
   logic [IRQ_W-1:0]  imask_r;
   logic [TICK_W-1:0] tick_cnt_r;
   logic [4:0]        ph_r;
   logic              boot_q_r;
   logic              unsol_q_r;
   logic              cfg_q_r;

   // apb decode
   wire        setup    = psel & ~penable;
   wire        acc_wr   = psel & penable & pwrite & pready & ~pslverr;
   wire        sel_axis = paddr == ADDR_AXIS;
   wire        sel_mode = paddr == ADDR_MODE;
   wire        sel_stat = paddr == ADDR_STAT;
   wire        sel_ist  = paddr == ADDR_ISTAT;
   wire        sel_imk  = paddr == ADDR_IMASK;
   wire        addr_ok  = sel_axis | sel_mode | sel_stat | sel_ist | sel_imk;

   // configuration decode
   wire [2:0]  axis_f   = axis_word_r[AXIS_LSB +: 3];
   wire        axis_bad = !(axis_f inside {AXIS_NONE, AXIS_ONE, AXIS_TWO});

   // pattern generator: tick every 50 ms, 32-tick frame
   wire        tick_hit = tick_cnt_r == TICK_W'(TICK_CYCLES - 1);
   wire        flk      = ph_r[0];                  // 50 ms on / 50 ms off
   wire        blk      = ph_r[2];                  // 200 ms on / 200 ms off
   wire        sfl      = ph_r < PH_ON;             // one 200 ms flash a frame
   wire        fl2      = ph_r >= PH_ON2A && ph_r < PH_ON2B;
   wire        dbl      = sfl | fl2;                // two 200 ms flashes a frame

   // error conditions from the controller
   wire        in_init  = slv.state == AL_INIT;
   wire        chg      = slv.change == CHG_ERR;
   wire        boot_err = in_init & chg;
   wire        unsol    = chg & ~in_init;
   wire        cfg_bad  = slv.cfg_err | axis_bad;

   // severity order: watchdogs, booting, configuration, state change
   wire err_mode_t err_mode =
        istat_r[IRQ_PDIWD] ? ERR_PDIWD :
        istat_r[IRQ_APPWD] ? ERR_APPWD :
        boot_err           ? ERR_BOOT  :
        cfg_bad            ? ERR_CFG   :
        unsol              ? ERR_UNSOL : ERR_NONE;

   // error pattern select
   wire        err_led_nxt =
        (err_mode == ERR_PDIWD) ? 1'b1 :
        (err_mode == ERR_APPWD) ? dbl  :
        (err_mode == ERR_BOOT)  ? flk  :
        (err_mode == ERR_CFG)   ? blk  :
        (err_mode == ERR_UNSOL) ? sfl  : 1'b0;

   // run pattern select; booting outranks any reported state
   wire        run_boot    = slv.booting | (slv.state == AL_BOOT);
   wire        run_led_nxt =
        run_boot                   ? flk  :
        (slv.state == AL_PREOP)    ? blk  :
        (slv.state == AL_SAFEOP)   ? sfl  :
        (slv.state == AL_OP)       ? 1'b1 : 1'b0;

   // events: watchdog pulses and rising edges of the level conditions
   wire [IRQ_W-1:0] ev;
   assign ev[IRQ_APPWD] = slv.app_wd;
   assign ev[IRQ_PDIWD] = slv.pdi_wd;
   assign ev[IRQ_BOOT]  = boot_err & ~boot_q_r;
   assign ev[IRQ_UNSOL] = unsol & ~unsol_q_r;
   assign ev[IRQ_CFG]   = cfg_bad & ~cfg_q_r;

   // write-one-to-clear; a new event in the clear cycle wins
   wire [IRQ_W-1:0] iclr = (acc_wr && sel_ist) ? pwdata[IRQ_W-1:0] : '0;
   assign istat_nxt = (istat_r & ~iclr) | ev;

   // read data mux; unused bits read zero
   wire [31:0] stat_word = {21'h0, axis_bad, error_indicator_led,
                            run_indicator_led, err_mode, slv.booting, slv.state};
   wire [31:0] rd_data =
        sel_axis ? {16'h0, axis_word_r} :
        sel_mode ? {16'h0, mode_word_r} :
        sel_stat ? stat_word :
        sel_ist  ? {27'h0, istat_r} :
        sel_imk  ? {27'h0, imask_r} : 32'h0;

   // apb answer: ready in the first access cycle, error on unmapped offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~addr_ok;
         prdata  <= (setup && !pwrite) ? rd_data : 32'h0;
      end
   end

   // software-written configuration and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         axis_word_r <= AXIS_RST;
         mode_word_r <= MODE_RST;
         imask_r     <= MASK_RST;
      end else begin
         if (acc_wr && sel_axis) axis_word_r <= pwdata[15:0];
         if (acc_wr && sel_mode) mode_word_r <= pwdata[15:0];
         if (acc_wr && sel_imk)  imask_r     <= pwdata[IRQ_W-1:0];
      end
   end

   // sticky status and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_r   <= '0;
         boot_q_r  <= 1'b0;
         unsol_q_r <= 1'b0;
         cfg_q_r   <= 1'b0;
      end else begin
         istat_r   <= istat_nxt;
         boot_q_r  <= boot_err;
         unsol_q_r <= unsol;
         cfg_q_r   <= cfg_bad;
      end
   end

   // tick counter and frame phase; one shared frame keeps both leds in step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r <= '0;
         ph_r       <= 5'h00;
      end else begin
         tick_cnt_r <= tick_hit ? '0 : tick_cnt_r + 1'b1;
         if (tick_hit) ph_r <= ph_r + 5'h01;
      end
   end

   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_indicator_led <= 1'b0;
         run_indicator_led   <= 1'b0;
         added_axis_count    <= 2'h0;
         axis_config_invalid <= 1'b0;
         remote_mode         <= 1'b0;
         count_units         <= 1'b0;
         irq                 <= 1'b0;
      end else begin
         error_indicator_led <= err_led_nxt;
         run_indicator_led   <= run_led_nxt;
         added_axis_count    <= axis_count_of(axis_f);
         axis_config_invalid <= axis_bad;
         remote_mode         <= mode_word_r[REMOTE_BIT];
         count_units         <= mode_word_r[UNITS_BIT];
         irq                 <= |(istat_nxt & imask_r);
      end
   end

   // checks on the indicator and configuration behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_err_dark_ok: assert property (
      err_mode == ERR_NONE |=> !error_indicator_led)
      else $error("error led lit with no error pending");

   a_boot_err_flick: assert property (
      boot_err && istat_r[IRQ_PDIWD:IRQ_APPWD] == 2'b00
      |=> error_indicator_led == $past(flk))
      else $error("booting error not flickering");

   a_unsol_flash: assert property (
      err_mode == ERR_UNSOL |=> error_indicator_led == $past(sfl))
      else $error("state change not single flash");

   a_app_wd_double: assert property (
      slv.app_wd && !slv.pdi_wd && !istat_r[IRQ_PDIWD] && !iclr[IRQ_APPWD]
      |=> ##1 error_indicator_led == $past(dbl))
      else $error("app watchdog not double flash");

   a_pdi_wd_on: assert property (
      slv.pdi_wd |=> ##1 error_indicator_led [*2])
      else $error("pdi watchdog not lit");

   a_run_init_dark: assert property (
      slv.state == AL_INIT && !slv.booting |=> !run_indicator_led)
      else $error("run led lit in init");

   a_run_preop_blink: assert property (
      slv.state == AL_PREOP && !slv.booting
      |=> run_indicator_led == $past(blk))
      else $error("run led not blinking in preop");

   a_run_safeop_flash: assert property (
      slv.state == AL_SAFEOP && !slv.booting
      |=> run_indicator_led == $past(sfl))
      else $error("run led not single flash in safeop");

   a_run_op_lit: assert property (
      slv.state == AL_OP && !slv.booting |=> run_indicator_led)
      else $error("run led dark in operational");

   a_run_boot_flick: assert property (
      run_boot |=> run_indicator_led == $past(flk))
      else $error("run led not flickering while booting");

   a_axis_two_count: assert property (
      axis_f == AXIS_TWO |=> added_axis_count == 2'h2 && !axis_config_invalid)
      else $error("two added axes decoded wrong");

   a_axis_invalid: assert property (
      axis_f[2] |=> axis_config_invalid && added_axis_count == 2'h0)
      else $error("illegal axis code not flagged");

   a_tick_phase: assert property (
      tick_hit |=> ph_r == $past(ph_r) + 5'h01 && tick_cnt_r == '0)
      else $error("frame phase did not advance on tick");

   a_pdi_over_boot: assert property (
      istat_r[IRQ_PDIWD] && boot_err |=> error_indicator_led)
      else $error("pdi watchdog not most severe");

   // apb answer timing and interrupt level
   // zero wait states: the master may rely on ready in the first access cycle
   a_pready_pulse: assert property (
      setup |=> pready ##1 !pready)
      else $error("apb ready not a one-cycle answer");

   a_slverr_unmapped: assert property (
      setup && !addr_ok |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");

   a_irq_follows: assert property (
      |(istat_r & imask_r) && !(acc_wr && sel_ist) |=> irq)
      else $error("irq low with unmasked status set");

   // main scenarios
   c_cfg_blink:   cover property (err_mode == ERR_CFG ##1 error_indicator_led);
   c_run_op:      cover property (slv.state == AL_OP ##1 run_indicator_led);
   c_double:      cover property (err_mode == ERR_APPWD ##1 error_indicator_led);
   c_irq_raised:  cover property (!irq ##1 irq);
   c_boot_flick:  cover property (err_mode == ERR_BOOT ##1 error_indicator_led);

endmodule : fieldbus_status_indicator

// ### fbs_pkg.sv
// package: constants and types for the fieldbus status indicator
package fbs_pkg;
   // apb register byte offsets
   localparam logic [7:0] ADDR_AXIS  = 8'h00;
   localparam logic [7:0] ADDR_MODE  = 8'h04;
   localparam logic [7:0] ADDR_STAT  = 8'h08;
   localparam logic [7:0] ADDR_ISTAT = 8'h0c;
   localparam logic [7:0] ADDR_IMASK = 8'h10;

   // configuration word fields
   localparam int unsigned AXIS_LSB   = 13;
   localparam int unsigned REMOTE_BIT = 9;
   localparam int unsigned UNITS_BIT  = 1;
   localparam logic [2:0]  AXIS_NONE  = 3'h0;
   localparam logic [2:0]  AXIS_ONE   = 3'h1;
   localparam logic [2:0]  AXIS_TWO   = 3'h2;

   // interrupt status / mask bit positions
   localparam int unsigned IRQ_APPWD = 0;
   localparam int unsigned IRQ_PDIWD = 1;
   localparam int unsigned IRQ_BOOT  = 2;
   localparam int unsigned IRQ_UNSOL = 3;
   localparam int unsigned IRQ_CFG   = 4;
   localparam int unsigned IRQ_W     = 5;

   // reset values
   localparam logic [15:0]      AXIS_RST = 16'h0000;
   localparam logic [15:0]      MODE_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;

   // slave state codes and change flag value
   localparam logic [3:0] AL_INIT   = 4'h1;
   localparam logic [3:0] AL_PREOP  = 4'h2;
   localparam logic [3:0] AL_BOOT   = 4'h3;
   localparam logic [3:0] AL_SAFEOP = 4'h4;
   localparam logic [3:0] AL_OP     = 4'h8;
   localparam logic [7:0] CHG_ERR   = 8'h01;

   // pattern timing: one tick is 50 ms, a frame is 32 ticks
   localparam int unsigned CLK_NS   = 10;
   localparam int unsigned TICK_NS  = 50_000_000;
   localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
   localparam int unsigned TICK_W   = 23;
   localparam logic [4:0]  PH_ON    = 5'h04;
   localparam logic [4:0]  PH_ON2A  = 5'h08;
   localparam logic [4:0]  PH_ON2B  = 5'h0c;

   // inputs from the protocol controller
   typedef struct packed {
      logic [3:0] state;
      logic       booting;
      logic [7:0] change;
      logic       cfg_err;
      logic       app_wd;
      logic       pdi_wd;
   } slave_status_t;

   // error indicator modes, lowest severity first
   typedef enum logic [2:0] {
      ERR_NONE, ERR_UNSOL, ERR_CFG, ERR_BOOT, ERR_APPWD, ERR_PDIWD
   } err_mode_t;
endpackage : fbs_pkg

// ### led_viewer.sv
// operator model: watches one front-panel led over a whole pattern frame
`timescale 1ns/1ns
module led_viewer #(
   parameter int unsigned TICKS = 4
)(
   // clock
   input  wire logic        pclk,
   // led as seen on the panel
   input  wire logic        led,
   // {lit ticks, on/off changes} over the last 32 ticks
   output logic      [11:0] look
);
   logic [31:0] seen_r;
   int unsigned cnt_r;

   // one look per tick, like an eye that cannot follow faster changes
   always_ff @(posedge pclk) begin
      cnt_r <= (cnt_r == TICKS - 1) ? 0 : cnt_r + 1;
      if (cnt_r == 0) seen_r <= {seen_r[30:0], led};
   end

   // changes are counted around the ring, so the frame phase does not matter
   assign look = {6'($countones(seen_r)), 6'($countones(seen_r ^ {seen_r[0], seen_r[31:1]}))};
endmodule : led_viewer

// ### tb_fieldbus_status_indicator.sv
// testbench: apb tasks, slave status stimulus and led pattern checks
`timescale 1ns/1ns
module tb_fieldbus_status_indicator;
   import fbs_pkg::*;
   localparam int unsigned TK    = 4;
   // expected {lit ticks, changes} per frame
   localparam logic [11:0] P_OFF = 12'h000;
   localparam logic [11:0] P_ON  = 12'h800;
   localparam logic [11:0] P_FLK = 12'h420;
   localparam logic [11:0] P_BLK = 12'h408;
   localparam logic [11:0] P_SGL = 12'h102;
   localparam logic [11:0] P_DBL = 12'h204;
   localparam logic [3:0]  RST [6] = '{AL_INIT, AL_PREOP, AL_SAFEOP, AL_OP, AL_BOOT, 4'h0};
   localparam logic [11:0] RPAT [6] = '{P_OFF, P_BLK, P_SGL, P_ON, P_FLK, P_FLK};

   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, rd;
   slave_status_t slv;
   logic          err_led, run_led, axis_inv, remote, units, err_seen;
   logic [1:0]    axis_cnt;
   logic [11:0]   err_look, run_look;
   int            n_fail, check_count;

   fieldbus_status_indicator #(.TICK_CYCLES(TK)) u_fieldbus_status_indicator (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slv(slv), .error_indicator_led(err_led), .run_indicator_led(run_led),
      .added_axis_count(axis_cnt), .axis_config_invalid(axis_inv), .remote_mode(remote),
      .count_units(units), .irq(irq));
   led_viewer #(.TICKS(TK)) u_led_viewer_err (.pclk(pclk), .led(err_led), .look(err_look));
   led_viewer #(.TICKS(TK)) u_led_viewer_run (.pclk(pclk), .led(run_led), .look(run_look));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_led(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t led pattern %h want %h", $time, got, exp);
      end
   endtask : chk_led

   // one apb transfer; waits for pready however long the slave takes
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // set the slave status and let a full frame pass by
   task automatic show(input logic [3:0] st, input logic bt, input logic [7:0] ch,
                       input logic ce);
      @(posedge pclk);
      slv.state <= st;
      slv.booting <= bt;
      slv.change <= ch;
      slv.cfg_err <= ce;
      repeat (34 * TK) @(posedge pclk);
   endtask : show

   // one-cycle watchdog pulse: 0 application, 1 process data
   task automatic pulse(input logic pdi);
      @(posedge pclk);
      if (pdi) slv.pdi_wd <= 1'b1;
      else slv.app_wd <= 1'b1;
      @(posedge pclk);
      slv.pdi_wd <= 1'b0;
      slv.app_wd <= 1'b0;
   endtask : pulse

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test

   // hang guard, well past the fewer than two thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      stop_test();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slv = '0;
      n_fail = 0;
      check_count = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // run led for every slave state, error led dark meanwhile
      for (int i = 0; i < 6; i++) begin
         show(RST[i], i == 5, 8'h00, 1'b0);
         chk_led(run_look, RPAT[i]);
         chk_led(err_look, P_OFF);
      end
      $display("test run indicator done");
      // error led: state change, booting, configuration, then both watchdogs, and back down
      show(AL_OP, 1'b0, CHG_ERR, 1'b0);
      chk_led(err_look, P_SGL);
      show(AL_INIT, 1'b0, CHG_ERR, 1'b0);
      chk_led(err_look, P_FLK);
      show(AL_INIT, 1'b0, 8'h00, 1'b1);
      chk_led(err_look, P_BLK);
      pulse(1'b0);
      show(AL_INIT, 1'b0, 8'h00, 1'b1);
      chk_led(err_look, P_DBL);
      pulse(1'b1);
      show(AL_INIT, 1'b0, CHG_ERR, 1'b1);
      chk_led(err_look, P_ON);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd, 32'h0000_02a1);
      apb(1'b1, ADDR_ISTAT, 32'h2);
      show(AL_INIT, 1'b0, CHG_ERR, 1'b1);
      chk_led(err_look, P_DBL);
      apb(1'b1, ADDR_ISTAT, 32'h1f);
      show(AL_OP, 1'b0, 8'h00, 1'b0);
      chk_led(err_look, P_OFF);
      $display("test error indicator done");
      // interrupt: masked event stays quiet, unmasked one raises irq until cleared
      apb(1'b1, ADDR_IMASK, 32'h2);
      apb(1'b0, ADDR_IMASK, 32'h0);
      chk(rd, 32'h2);
      pulse(1'b0);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      pulse(1'b1);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, ADDR_ISTAT, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, ADDR_ISTAT, 32'h2);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ADDR_ISTAT, 32'h1f);
      $display("test interrupt done");
      // added-axis codes, legal and not, then mode bits
      for (int j = 0; j < 5; j++) begin
         apb(1'b1, ADDR_AXIS, 32'(j << AXIS_LSB));
         repeat (2) @(posedge pclk);
         chk({29'h0, axis_inv, axis_cnt}, {29'h0, j > 2, (j > 2) ? 2'h0 : 2'(j)});
      end
      apb(1'b0, ADDR_AXIS, 32'h0);
      chk(rd, 32'h8000);
      apb(1'b1, ADDR_MODE, 32'h0202);
      repeat (2) @(posedge pclk);
      chk({30'h0, remote, units}, 32'h3);
      apb(1'b1, ADDR_MODE, 32'h0200);
      repeat (2) @(posedge pclk);
      chk({30'h0, remote, units}, 32'h2);
      // unmapped place: error answer, nothing read back
      apb(1'b1, 8'h20, 32'hffff_ffff);
      chk({31'h0, err_seen}, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err_seen}, 32'h1);
      $display("test configuration done");
      stop_test();
   end
endmodule : tb_fieldbus_status_indicator
